// ===== src/adcsq_pkg.sv
/*
  shared constants for the converter sequence control block: register indices,
  field positions, reset values, mode codes and conversion cycle counts.
  assumes one fc cycle per core_clk cycle.
*/
package adcsq_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] CTL_ONE_IDX    = 8'h1C;
  localparam logic [7:0] CTL_TWO_IDX    = 8'h1D;
  localparam logic [7:0] RES_LOW_IDX    = 8'h1E;
  localparam logic [7:0] RES_HIGH_IDX   = 8'h1F;

  // control one fields
  localparam int START_BIT      = 7;
  localparam int MODE_HI        = 6;
  localparam int MODE_LO        = 5;
  localparam int IN_DIS_BIT     = 4;
  localparam int CHAN_HI        = 3;
  localparam logic [7:0] CTL_ONE_RESET = 8'h10;

  // control two fields
  localparam int LADDER_BIT     = 5;
  localparam int FIXED_ONE_BIT  = 4;
  localparam int TIME_HI        = 3;
  localparam int TIME_LO        = 1;
  localparam logic [3:0] CTL_TWO_RESET = 4'h0;

  // result low / status fields
  localparam int EOC_BIT        = 5;
  localparam int BUSY_BIT       = 4;

  // operating modes
  localparam logic [1:0] MODE_OFF    = 2'b00;
  localparam logic [1:0] MODE_SINGLE = 2'b01;
  localparam logic [1:0] MODE_REPEAT = 2'b11;

  // channel codes above this are reserved
  localparam logic [3:0] CHAN_LAST   = 4'h7;

  // conversion times in fc cycles
  localparam int CONV_FC_000 = 39;
  localparam int CONV_FC_010 = 78;
  localparam int CONV_FC_011 = 156;
  localparam int CONV_FC_100 = 312;
  localparam int CONV_FC_101 = 624;
  localparam int CONV_FC_110 = 1248;
  localparam int FC_PER_CLK  = 1;
  localparam int CNT_W       = 11;

  // successive approximation timing
  localparam int RES_W       = 10;
  localparam int TRIAL_CYC   = 3;

  typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_CONV} adcsq_state_t;

  function automatic logic [CNT_W-1:0] convCycles(input logic [2:0] code);
    case (code)
      3'b000:  convCycles = CNT_W'(CONV_FC_000 * FC_PER_CLK);
      3'b010:  convCycles = CNT_W'(CONV_FC_010 * FC_PER_CLK);
      3'b011:  convCycles = CNT_W'(CONV_FC_011 * FC_PER_CLK);
      3'b100:  convCycles = CNT_W'(CONV_FC_100 * FC_PER_CLK);
      3'b101:  convCycles = CNT_W'(CONV_FC_101 * FC_PER_CLK);
      default: convCycles = CNT_W'(CONV_FC_110 * FC_PER_CLK);
    endcase
  endfunction

endpackage

// ===== src/adcsq_conv_timer.sv
/*
  conversion duration counter: loads the cycle count for the time code on
  start and pulses done when it elapses.
  assumes start and abort come from logic on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module adcsq_conv_timer
  import adcsq_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // control
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [2:0] timeCode,
  // status
  output logic            done
);
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic             run_reg;
  logic             run_next;

  // done never looks at start: a restart fed back from done cannot form a loop
  always_comb begin
    count_next = count_reg;
    run_next   = run_reg;
    done       = run_reg && (count_reg == '0);
    if (abort) begin
      run_next = 1'b0;
    end else if (start) begin
      count_next = convCycles(timeCode) - CNT_W'(1);
      run_next   = 1'b1;
    end else if (run_reg) begin
      if (done) begin
        run_next = 1'b0;
      end else begin
        count_next = count_reg - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
      run_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      run_reg   <= run_next;
    end
  end
endmodule
`default_nettype wire

// ===== src/adcsq_sar_engine.sv
/*
  successive approximation register: drives the trial code to the ladder dac
  and keeps or drops each bit from the comparator, msb first.
  assumes the comparator output is asynchronous and settles within a trial.
*/
`timescale 1ns/1ps
`default_nettype none
module adcsq_sar_engine
  import adcsq_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // control
  input  wire logic             start,
  // analog side
  input  wire logic             compAbove,
  output logic [RES_W-1:0]      dacCode,
  // result
  output logic [RES_W-1:0]      approx
);
  logic             compMeta_reg;
  logic             compSync_reg;
  logic [RES_W-1:0] approx_reg;
  logic [RES_W-1:0] approx_next;
  logic [RES_W-1:0] trial_reg;
  logic [RES_W-1:0] trial_next;
  logic [1:0]       phase_reg;
  logic [1:0]       phase_next;

  assign dacCode = approx_reg | trial_reg;
  assign approx  = approx_reg;

  always_comb begin
    approx_next = approx_reg;
    trial_next  = trial_reg;
    phase_next  = phase_reg;
    if (start) begin
      approx_next = '0;
      trial_next  = {1'b1, {(RES_W-1){1'b0}}};
      phase_next  = '0;
    end else if (trial_reg != '0) begin
      if (phase_reg == 2'(TRIAL_CYC - 1)) begin
        phase_next = '0;
        if (compSync_reg) begin
          approx_next = approx_reg | trial_reg;
        end
        trial_next = trial_reg >> 1;
      end else begin
        phase_next = phase_reg + 2'd1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      compMeta_reg <= 1'b0;
      compSync_reg <= 1'b0;
      approx_reg   <= '0;
      trial_reg    <= '0;
      phase_reg    <= '0;
    end else begin
      compMeta_reg <= compAbove;
      compSync_reg <= compMeta_reg;
      approx_reg   <= approx_next;
      trial_reg    <= trial_next;
      phase_reg    <= phase_next;
    end
  end
endmodule
`default_nettype wire

// ===== src/adcsq_control.sv
/*
  control and status of a 10-bit successive approximation converter, reached
  over apb: two control registers, two result registers, start, repeat,
  abort on low-power entry and the completion pulse.
  assumes low-power mode levels come from logic on core_clk and the
  comparator output arrives asynchronously from the analog block.
*/
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module adcsq_control
  import adcsq_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // chip power modes
  input  wire logic        stopMode,
  input  wire logic        slowMode,
  input  wire logic        sleepMode,
  // analog side
  input  wire logic        compAbove,
  output logic [RES_W-1:0] dacCode,
  output logic [2:0]       analogChannel,
  output logic             channelValid,
  output logic             analogInputEnable,
  output logic             ladderConnect,
  output logic             sampleActive,
  // interrupt request
  output logic             conversionCompleteIrq
);
  adcsq_state_t     state_reg;
  adcsq_state_t     state_next;
  logic [7:0]       ctlOne_reg;
  logic [7:0]       ctlOne_next;
  logic [3:0]       ctlTwo_reg;
  logic [3:0]       ctlTwo_next;
  logic [RES_W-1:0] result_reg;
  logic [RES_W-1:0] result_next;
  logic             eoc_reg;
  logic             eoc_next;
  logic             busy_reg;
  logic             busy_next;
  logic             irq_reg;
  logic             irq_next;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;
  logic             err_reg;
  logic             err_next;

  logic             setupPhase;
  logic             accessDone;
  logic             wrOne;
  logic             wrTwo;
  logic             rdHigh;
  logic             lowPower;
  logic             abortPower;
  logic             beginConv;
  logic             timerDone;
  logic             abortConv;
  logic [1:0]       mode;
  logic [RES_W-1:0] approx;
  logic [7:0]       wrByte;

  function automatic logic hitIdx(input logic [11:0] addr, input logic [7:0] idx);
    hitIdx = (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
  endfunction

  // apb decode
  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable;
  assign wrByte     = pstrb[0] ? pwdata[7:0] : 8'h00;
  assign lowPower   = stopMode || slowMode || sleepMode;
  assign abortPower = stopMode || slowMode;
  assign wrOne      = accessDone && pwrite && pstrb[0] && hitIdx(paddr, CTL_ONE_IDX)
                      && !lowPower;
  assign wrTwo      = accessDone && pwrite && pstrb[0] && hitIdx(paddr, CTL_TWO_IDX)
                      && !lowPower;
  assign rdHigh     = accessDone && !pwrite && hitIdx(paddr, RES_HIGH_IDX);
  assign mode       = ctlOne_reg[MODE_HI:MODE_LO];

  assign pready     = 1'b1;
  assign pslverr    = err_reg && accessDone;
  assign prdata     = rdata_reg;

  // read data and error captured in the setup cycle
  always_comb begin
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (setupPhase) begin
      err_next   = 1'b0;
      rdata_next = 32'h0000_0000;
      if (hitIdx(paddr, CTL_ONE_IDX)) begin
        rdata_next[7:0] = ctlOne_reg;
      end else if (hitIdx(paddr, CTL_TWO_IDX)) begin
        rdata_next[7:0] = {2'b00, ctlTwo_reg[3], 1'b1, ctlTwo_reg[2:0], 1'b0};
      end else if (hitIdx(paddr, RES_LOW_IDX)) begin
        rdata_next[7:0] = {result_reg[1:0], eoc_reg, busy_reg, 4'h0};
      end else if (hitIdx(paddr, RES_HIGH_IDX)) begin
        rdata_next[7:0] = result_reg[RES_W-1:2];
      end else begin
        err_next = 1'b1;
      end
    end
  end

  // abort when the mode is no longer a converting one, or on stop or slow
  assign abortConv = busy_reg && (abortPower
                     || (mode != MODE_SINGLE && mode != MODE_REPEAT));
  // start bit launches when mode allows and nothing runs
  assign beginConv = !abortPower && !busy_reg && ctlOne_reg[START_BIT]
                     && (mode == MODE_SINGLE || mode == MODE_REPEAT);

  // control registers
  always_comb begin
    ctlOne_next = ctlOne_reg;
    ctlTwo_next = ctlTwo_reg;
    if (lowPower) begin
      ctlOne_next = CTL_ONE_RESET;
      ctlTwo_next = CTL_TWO_RESET;
    end else begin
      if (wrOne) begin
        ctlOne_next = wrByte;
      end else if (beginConv) begin
        ctlOne_next[START_BIT] = 1'b0;
      end
      if (wrTwo) begin
        ctlTwo_next = {wrByte[LADDER_BIT], wrByte[TIME_HI:TIME_LO]};
      end
    end
  end

  // conversion sequencing, result and flags
  always_comb begin
    state_next  = state_reg;
    result_next = result_reg;
    eoc_next    = eoc_reg;
    busy_next   = busy_reg;
    irq_next    = 1'b0;
    if (rdHigh) begin
      eoc_next = 1'b0;
    end
    case (state_reg)
      ADCSQ_IDLE: begin
        if (beginConv) begin
          state_next = ADCSQ_CONV;
          busy_next  = 1'b1;
          eoc_next   = 1'b0;
        end
      end
      ADCSQ_CONV: begin
        if (abortConv) begin
          state_next = ADCSQ_IDLE;
          busy_next  = 1'b0;
        end else if (timerDone) begin
          result_next = approx;
          eoc_next    = 1'b1;
          irq_next    = 1'b1;
          if (mode == MODE_REPEAT) begin
            state_next = ADCSQ_CONV;
          end else begin
            state_next = ADCSQ_IDLE;
            busy_next  = 1'b0;
          end
        end
      end
      default: begin
        state_next = ADCSQ_IDLE;
        busy_next  = 1'b0;
      end
    endcase
    if (abortPower) begin
      result_next = '0;
      eoc_next    = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg  <= ADCSQ_IDLE;
      ctlOne_reg <= CTL_ONE_RESET;
      ctlTwo_reg <= CTL_TWO_RESET;
      result_reg <= '0;
      eoc_reg    <= 1'b0;
      busy_reg   <= 1'b0;
      irq_reg    <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      err_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      ctlOne_reg <= ctlOne_next;
      ctlTwo_reg <= ctlTwo_next;
      result_reg <= result_next;
      eoc_reg    <= eoc_next;
      busy_reg   <= busy_next;
      irq_reg    <= irq_next;
      rdata_reg  <= rdata_next;
      err_reg    <= err_next;
    end
  end

  // restart in repeat mode reloads timer and approximation
  logic convStart;
  assign convStart = beginConv || (timerDone && !abortConv && mode == MODE_REPEAT
                     && state_reg == ADCSQ_CONV);

  adcsq_conv_timer u_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .start    (convStart),
    .abort    (abortConv),
    .timeCode (ctlTwo_reg[2:0]),
    .done     (timerDone)
  );

  adcsq_sar_engine u_sar (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .start     (convStart),
    .compAbove (compAbove),
    .dacCode   (dacCode),
    .approx    (approx)
  );

  // analog controls
  assign analogChannel         = ctlOne_reg[2:0];
  assign channelValid          = ctlOne_reg[CHAN_HI:0] <= CHAN_LAST;
  assign analogInputEnable     = !ctlOne_reg[IN_DIS_BIT];
  assign ladderConnect         = !abortPower && (ctlTwo_reg[3] || busy_reg);
  assign sampleActive          = busy_reg;
  assign conversionCompleteIrq = irq_reg;

endmodule
`default_nettype wire

// ===== tb/adcsq_control_checker.sv
/*
  concurrent checks on the converter control ports.
  assumes core_clk and active-low rstn of the top module.
*/
`timescale 1ns/1ps
`default_nettype none
module adcsq_control_checker (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // power and converter
  input wire logic        stopMode,
  input wire logic        slowMode,
  input wire logic        sampleActive,
  input wire logic        ladderConnect,
  input wire logic        conversionCompleteIrq
);
  logic lowPower;
  assign lowPower = stopMode | slowMode;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_quiet;
    !conversionCompleteIrq [*8];
  endsequence
  sequence s_start;
    $rose(sampleActive);
  endsequence
  a_irq_spacing: assert property (conversionCompleteIrq |=> s_quiet)
    else $error("completion pulse too long or too close");
  a_busy_min_time: assert property (s_start |-> s_quiet)
    else $error("completion too soon after start");
  a_irq_from_busy: assert property (conversionCompleteIrq |-> $past(sampleActive))
    else $error("completion without a running conversion");
  a_busy_low_power: assert property (lowPower |=> !sampleActive)
    else $error("busy kept in low power");
  a_ladder_low_power: assert property (lowPower |=> !ladderConnect)
    else $error("ladder kept in low power");
  a_irq_low_power: assert property (lowPower |=> !conversionCompleteIrq)
    else $error("completion in low power");
  a_ladder_conv: assert property (!lowPower && sampleActive
      && $past(sampleActive) |-> ladderConnect)
    else $error("ladder off while converting");
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("access phase not ready");
  a_mapped_ok: assert property (psel && penable && paddr[11:4] == 8'h07
      && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("error on mapped register");
  a_unmapped_err: assert property (psel && penable && paddr[11:4] != 8'h07 |-> pslverr)
    else $error("no error on unmapped address");
endmodule
bind adcsq_control adcsq_control_checker adcsq_control_checker_inst (
  .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .stopMode(stopMode),
  .slowMode(slowMode), .sampleActive(sampleActive),
  .ladderConnect(ladderConnect), .conversionCompleteIrq(conversionCompleteIrq)
);
`default_nettype wire

// ===== tb/testbench.sv
/*
  self-checking bench for the converter control block over apb.
  assumes zero wait state apb and one fc cycle per core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import adcsq_pkg::*;
;
  localparam logic [11:0] A1 = {2'b00, CTL_ONE_IDX, 2'b00};
  localparam logic [11:0] A2 = {2'b00, CTL_TWO_IDX, 2'b00};
  localparam logic [11:0] A3 = {2'b00, RES_LOW_IDX, 2'b00};
  localparam logic [11:0] A4 = {2'b00, RES_HIGH_IDX, 2'b00};
  logic             core_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic             stopMode, slowMode, sleepMode, compAbove, lastErr;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata;
  logic [3:0]       pstrb;
  logic [RES_W-1:0] dacCode;
  logic [2:0]       analogChannel;
  logic             channelValid, analogInputEnable, ladderConnect;
  logic             sampleActive, conversionCompleteIrq;
  int               errors, comparisons, cycles;

  adcsq_control adcsq_control_inst (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .stopMode(stopMode),
    .slowMode(slowMode), .sleepMode(sleepMode), .compAbove(compAbove),
    .dacCode(dacCode), .analogChannel(analogChannel), .channelValid(channelValid),
    .analogInputEnable(analogInputEnable), .ladderConnect(ladderConnect),
    .sampleActive(sampleActive), .conversionCompleteIrq(conversionCompleteIrq)
  );

  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer: setup, access until ready, release
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] rd);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    apb(1'b0, a, 8'h00, x);
    chk(x, e);
  endtask

  // edges from now until the completion pulse is seen
  task automatic waitIrq(input int n);
    int k;
    k = 0;
    while (conversionCompleteIrq !== 1'b1 && k < 3000) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (n != 0) begin
      chk(k, n);
    end else begin
      chk(32'(k < 3000), 32'h0000_0001);
    end
  endtask

  task automatic t_reset();
    rdchk(A1, 32'h0000_0010);
    rdchk(A2, 32'h0000_0010);
    rdchk(A3, 32'h0000_0000);
    rdchk(A4, 32'h0000_0000);
    rdchk(12'h080, 32'h0000_0000);
    chk(lastErr, 1);
  endtask

  task automatic t_channel();
    wr(A1, 8'h08);
    #1;
    chk(channelValid, 0);
    wr(A1, 8'h07);
    pstrb <= 4'hE;
    #1;
    chk({analogInputEnable, channelValid, analogChannel}, 5'h1F);
    wr(A1, 8'h02);
    pstrb <= 4'hF;
    rdchk(A1, 32'h0000_0007);
  endtask

  task automatic t_single();
    wr(A2, 8'h10);
    compAbove <= 1'b1;
    wr(A1, 8'hA3);
    @(posedge core_clk);
    #1;
    chk({sampleActive, ladderConnect, analogChannel}, 5'h1B);
    waitIrq(39);
    chk(sampleActive, 0);
    rdchk(A1, 32'h0000_0023);
    rdchk(A3, 32'h0000_00E0);
    compAbove <= 1'b0;
    wr(A1, 8'hA3);
    rdchk(A3, 32'h0000_00D0);
    rdchk(A4, 32'h0000_00FF);
    waitIrq(0);
    rdchk(A3, 32'h0000_0020);
    rdchk(A4, 32'h0000_0000);
    rdchk(A3, 32'h0000_0000);
    chk(ladderConnect, 0);
  endtask

  task automatic t_times();
    logic [2:0] codes [8] = '{3'b000, 3'b010, 3'b011, 3'b100, 3'b101, 3'b110, 3'b001, 3'b111};
    int         lens [8] = '{39, 78, 156, 312, 624, 1248, 1248, 1248};
    for (int i = 0; i < 8; i++) begin
      wr(A2, {3'b001, codes[i], 1'b0});
      wr(A1, 8'hA0);
      @(posedge core_clk);
      #1;
      chk(sampleActive, 1);
      waitIrq(lens[i]);
    end
  endtask

  task automatic t_repeat();
    int n;
    n = 0;
    wr(A2, 8'h10);
    wr(A1, 8'hE0);
    @(posedge core_clk);
    #1;
    waitIrq(39);
    @(posedge core_clk);
    #1;
    waitIrq(38);
    wr(A1, 8'h00);
    repeat (60) begin
      @(posedge core_clk);
      #1;
      if (conversionCompleteIrq === 1'b1) n++;
    end
    chk({n[30:0], sampleActive}, 0);
  endtask

  task automatic t_power();
    for (int i = 0; i < 2; i++) begin
      wr(A2, 8'h30);
      compAbove <= 1'b1;
      wr(A1, 8'hA5);
      waitIrq(0);
      wr(A1, 8'hA5);
      repeat (3) @(posedge core_clk);
      chk(sampleActive, 1);
      if (i == 0) stopMode <= 1'b1;
      else slowMode <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      chk({sampleActive, ladderConnect}, 0);
      wr(A2, 8'h3E);
      rdchk(A2, 32'h0000_0010);
      rdchk(A1, 32'h0000_0010);
      rdchk(A4, 32'h0000_0000);
      stopMode <= 1'b0;
      slowMode <= 1'b0;
    end
    wr(A2, 8'h30);
    sleepMode <= 1'b1;
    wr(A2, 8'h3E);
    rdchk(A2, 32'h0000_0010);
    sleepMode <= 1'b0;
  endtask

  initial begin
    {core_clk, rstn, psel, penable, pwrite, stopMode, slowMode} = '0;
    {sleepMode, compAbove, paddr, pwdata} = '0;
    {errors, comparisons, cycles} = '0;
    pstrb = 4'hF;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset();
    t_channel();
    t_single();
    t_times();
    t_repeat();
    t_power();
    end_sim();
  end
endmodule
`default_nettype wire
